// File: mcls_regs.vh
// register map, field positions and reset values of the carrier low stage
// Overview of operation
// - pin release bit set detaches chosen compare unit from its own pin
// - invert bit set inverts the selected carrier low source
// - edge wait set holds carrier low until its falling edge
// - edge wait clear switches away at once on modulation change
// - code 1111 second ref clock, 1110 system clock, 0011 first ref clock
// - codes 0100..1101 pick three enhanced then compare units four to ten
// - 0010 second input pin, 0001 first pin, 0000 constant low
// - bit 4 of control register reads zero, writes ignored
// - every reset leaves the modulator disabled
// - enable bit gates all mixing; clear holds mod output low
`ifndef MCLS_REGS_VH
`define MCLS_REGS_VH
`define MCLS_ADDR_CARL 12'h000
`define MCLS_ADDR_CTRL 12'h004
`define MCLS_ADDR_STAT 12'h008
`define MCLS_CARL_RELEASE 7
`define MCLS_CARL_INVERT 6
`define MCLS_CARL_WAIT 5
`define MCLS_CARL_WMASK 8'hEF
`define MCLS_CARL_RESET 8'h00
`define MCLS_CTRL_ENABLE 7
`define MCLS_CTRL_RESET 8'h00
`define MCLS_CTRL_WMASK 8'h80
`define MCLS_SRC_NONE 4'h0
`define MCLS_SRC_PIN1 4'h1
`define MCLS_SRC_PIN2 4'h2
`define MCLS_SRC_REF1 4'h3
`define MCLS_SRC_CMP_LO 4'h4
`define MCLS_SRC_CMP_HI 4'hD
`define MCLS_SRC_SYSCLK 4'hE
`define MCLS_SRC_REF2 4'hF
`endif

// File: mcls_src_mux.v
// carrier low source selector
`timescale 1ns/1ps
`default_nettype none
`include "mcls_regs.vh"
module mcls_src_mux #(
	parameter NUM_CMP = 10
) (
	input wire [3:0] sel_in,
	input wire sys_clk_level_in,
	input wire first_reference_clock_output_in,
	input wire second_reference_clock_output_in,
	input wire first_carrier_input_pin_in,
	input wire second_carrier_input_pin_in,
	input wire [NUM_CMP-1:0] compare_unit_pwm_in,
	input wire [NUM_CMP-1:0] compare_unit_pwm_mode_in,
	output reg src_out,
	output reg [NUM_CMP-1:0] pin_sel_out
);
	wire [3:0] cmp_idx;
	assign cmp_idx = sel_in - `MCLS_SRC_CMP_LO;
	always @* begin
		src_out = 1'b0;
		pin_sel_out = {NUM_CMP{1'b0}};
		case (sel_in)
			`MCLS_SRC_NONE: src_out = 1'b0;
			`MCLS_SRC_PIN1: src_out = first_carrier_input_pin_in;
			`MCLS_SRC_PIN2: src_out = second_carrier_input_pin_in;
			`MCLS_SRC_REF1: src_out = first_reference_clock_output_in;
			`MCLS_SRC_SYSCLK: src_out = sys_clk_level_in;
			`MCLS_SRC_REF2: src_out = second_reference_clock_output_in;
			default: begin
				// compare unit only in pwm mode
				src_out = compare_unit_pwm_in[cmp_idx] &
					compare_unit_pwm_mode_in[cmp_idx];
				pin_sel_out[cmp_idx] = 1'b1;
			end
		endcase
	end
endmodule // mcls_src_mux
`default_nettype wire

// File: mcls_top.v
// carrier low selection stage with apb registers
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "mcls_regs.vh"
module mcls_top #(
	parameter NUM_CMP = 10
) (
	input wire sys_clk_in,
	input wire sys_rst_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out,
	input wire sys_clk_level_in,
	input wire first_reference_clock_output_in,
	input wire second_reference_clock_output_in,
	input wire first_carrier_input_pin_in,
	input wire second_carrier_input_pin_in,
	input wire [NUM_CMP-1:0] compare_unit_pwm_in,
	input wire [NUM_CMP-1:0] compare_unit_pwm_mode_in,
	input wire carrier_high_in,
	input wire modulation_in,
	output reg mod_out,
	output reg carrier_low_out,
	output reg [NUM_CMP-1:0] compare_pin_release_out
);
	reg [7:0] carl_q;
	reg [7:0] ctrl_q;
	reg cl_prev_q;
	reg hold_low_q;
	reg mod_d;
	wire src_raw;
	wire cl_cond;
	wire cl_fall;
	wire [NUM_CMP-1:0] pin_sel;
	wire wr_acc;
	wire rd_acc;
	wire addr_ok;
	// bus decode
	wire sel_carl;
	wire sel_ctrl;
	wire sel_stat;
	wire setup_ph;
	wire access_ph;
	reg [31:0] rd_word;

	// one address compare, shared by the write and read decoders
	function addr_is;
		input [11:0] addr;
		input [11:0] target;
		begin
			addr_is = (addr == target);
		end
	endfunction

	// zero extend an 8-bit register into the bus word
	function [31:0] widen8;
		input [7:0] val;
		begin
			widen8 = {24'h000000, val};
		end
	endfunction

	mcls_src_mux #(.NUM_CMP(NUM_CMP)) u_mux (
		.sel_in(carl_q[3:0]),
		.sys_clk_level_in(sys_clk_level_in),
		.first_reference_clock_output_in(first_reference_clock_output_in),
		.second_reference_clock_output_in(second_reference_clock_output_in),
		.first_carrier_input_pin_in(first_carrier_input_pin_in),
		.second_carrier_input_pin_in(second_carrier_input_pin_in),
		.compare_unit_pwm_in(compare_unit_pwm_in),
		.compare_unit_pwm_mode_in(compare_unit_pwm_mode_in),
		.src_out(src_raw),
		.pin_sel_out(pin_sel)
	);

	assign cl_cond = src_raw ^ carl_q[`MCLS_CARL_INVERT];
	assign cl_fall = cl_prev_q & ~cl_cond;

	// address decode
	assign sel_carl = addr_is(paddr_in, `MCLS_ADDR_CARL);
	assign sel_ctrl = addr_is(paddr_in, `MCLS_ADDR_CTRL);
	assign sel_stat = addr_is(paddr_in, `MCLS_ADDR_STAT);
	assign addr_ok = sel_carl | sel_ctrl | sel_stat;

	// bus phases; ready is ours, so the access edge is the one it is high
	assign setup_ph = psel_in & ~penable_in;
	assign access_ph = psel_in & penable_in;
	assign wr_acc = access_ph & pwrite_in & pready_out;
	assign rd_acc = setup_ph & ~pwrite_in;

	// read word picked in setup, registered for the access phase
	always @* begin
		rd_word = 32'h00000000;
		if (sel_carl)
			rd_word = widen8(carl_q);
		else if (sel_ctrl)
			rd_word = widen8(ctrl_q);
		else if (sel_stat)
			rd_word = {29'h0000000, hold_low_q, carrier_low_out, mod_out};
	end

	// handshake: no wait state, answer in the first access phase cycle
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= setup_ph;
			// unmapped address flagged with the ready pulse
			pslverr_out <= setup_ph & ~addr_ok;
		end
	end

	// read data stands only with ready; zero otherwise, so a stale
	// value never shows up in a later write or error response
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			prdata_out <= 32'h00000000;
		end else if (rd_acc) begin
			prdata_out <= rd_word;
		end else begin
			prdata_out <= 32'h00000000;
		end
	end

	// carrier low control register
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			carl_q <= `MCLS_CARL_RESET;
		end else if (wr_acc && sel_carl) begin
			carl_q <= pwdata_in[7:0] & `MCLS_CARL_WMASK;
		end
	end

	// modulator control register: only the enable bit exists
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			ctrl_q <= `MCLS_CTRL_RESET;
		end else if (wr_acc && sel_ctrl) begin
			ctrl_q <= pwdata_in[7:0] & `MCLS_CTRL_WMASK;
		end
	end

	// modulation path
	always @* begin
		mod_d = 1'b0;
		if (ctrl_q[`MCLS_CTRL_ENABLE]) begin
			if (modulation_in && !hold_low_q)
				mod_d = carrier_high_in;
			else
				mod_d = cl_cond;
		end
	end

	// previous carrier low level, for falling edge detection
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			cl_prev_q <= 1'b0;
		end else begin
			cl_prev_q <= cl_cond;
		end
	end

	// stay on carrier low until falling edge
	// armed while modulation is low, so a rise is caught at once
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			hold_low_q <= 1'b0;
		end else if (!carl_q[`MCLS_CARL_WAIT]) begin
			hold_low_q <= 1'b0;
		end else if (!modulation_in || !ctrl_q[`MCLS_CTRL_ENABLE]) begin
			hold_low_q <= ctrl_q[`MCLS_CTRL_ENABLE];
		end else if (cl_fall) begin
			hold_low_q <= 1'b0;
		end
	end

	// registered outputs of the datapath
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			mod_out <= 1'b0;
			carrier_low_out <= 1'b0;
		end else begin
			carrier_low_out <= cl_cond;
			mod_out <= mod_d;
		end
	end

	// release the selected unit's pin
	// only compare units own a pin here; clocks and input pins do not
	always @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			compare_pin_release_out <= {NUM_CMP{1'b0}};
		end else if (carl_q[`MCLS_CARL_RELEASE]) begin
			compare_pin_release_out <= pin_sel;
		end else begin
			compare_pin_release_out <= {NUM_CMP{1'b0}};
		end
	end
endmodule // mcls_top
`default_nettype wire

// File: mcls_asserts.sv
// port checks for the carrier low stage
`timescale 1ns/1ps
`default_nettype none
module mcls_asserts (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic carrier_high_in,
	input wire logic modulation_in,
	input wire logic mod_out,
	input wire logic carrier_low_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	a_ready_next: assert property (psel_in && !penable_in |=> pready_out)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("ready held");
	a_err_map: assert property (pready_out && paddr_in > 12'h8 |-> pslverr_out)
		else $error("unmapped accepted");
	a_err_zero: assert property (pslverr_out |-> prdata_out == 32'h0)
		else $error("error read not zero");
	a_bit4_zero: assert property (pready_out && !paddr_in |-> !prdata_out[4])
		else $error("bit 4 set");
	a_reset_quiet: assert property ($fell(sys_rst_in) |-> !mod_out)
		else $error("output after reset");
	a_low_pass:
	assert property (!modulation_in |=> carrier_low_out || !mod_out)
		else $error("low carrier not passed");
	a_high_pick:
	assert property (modulation_in |=> !mod_out || carrier_low_out
		|| $past(carrier_high_in)) else $error("high carrier not passed");
endmodule // mcls_asserts
bind mcls_top mcls_asserts u_chk (.*);
`default_nettype wire

// File: mcls_partner.sv
// lfsr stand-in for the carrier source peripherals
`timescale 1ns/1ps
`default_nettype none
module mcls_partner (
	input wire logic clk_in,
	input wire logic rst_in,
	output logic [15:0] src_out
);
	// full-length taps; each source above bit 0 repeats its lower neighbour one cycle later
	always_ff @(posedge clk_in)
		if (rst_in) src_out <= 16'hACE1;
		else src_out <= {src_out[14:0], ^(src_out & 16'hB400)};
endmodule // mcls_partner
`default_nettype wire

// File: mcls_bench.sv
// self-checking bench of the carrier low stage
`timescale 1ns/1ps
`default_nettype none
module mcls_bench;
	logic sys_clk_in = 1'h0, sys_rst_in = 1'h1, psel_in = 1'h0, e;
	logic penable_in = 1'h0, pwrite_in = 1'h0, modulation_in = 1'h0;
	logic [11:0] paddr_in = 12'h0;
	logic [31:0] pwdata_in = 32'h0, rd;
	logic [9:0] compare_unit_pwm_mode_in = 10'h155, r;
	wire [31:0] prdata_out;
	wire [15:0] v;
	wire [9:0] compare_pin_release_out;
	wire pready_out, pslverr_out, mod_out, carrier_low_out;
	int fail_count = 0, compares = 0, cyc = 0;
	mcls_partner u_src (.clk_in(sys_clk_in), .rst_in(sys_rst_in), .src_out(v));
	mcls_top DUT (.*, .first_carrier_input_pin_in(v[0]),
		.second_carrier_input_pin_in(v[1]), .compare_unit_pwm_in(v[12:3]),
		.first_reference_clock_output_in(v[2]), .sys_clk_level_in(v[13]),
		.second_reference_clock_output_in(v[14]), .carrier_high_in(v[15]));
	initial forever #5 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) if (++cyc > 2000) final_report;
	task automatic chk(input logic [31:0] g, x);
		compares++;
		fail_count += g !== x;
		if (g !== x) $display("BAD %0t got %h want %h", $time, g, x);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		{psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'h1, w, a, 24'h0, d};
		@(posedge sys_clk_in);
		penable_in <= 1'h1;
		do @(posedge sys_clk_in); while (pready_out !== 1'h1);
		rd = {pslverr_out, prdata_out[30:0]};
		{psel_in, penable_in} <= 2'h0;
	endtask
	task automatic t_src;
		int k;
		apb(1'h1, 12'h0, 8'hFF);
		apb(1'h0, 12'h0, 8'h0);
		chk(rd, 32'hEF);
		apb(1'h0, 12'h00C, 8'h0);
		chk(rd, 32'h80000000);
		for (int c = 0; c < 32; c++) begin
			apb(1'h1, 12'h0, {c[4], c[4], 2'h0, c[3:0]});
			repeat (2) @(posedge sys_clk_in);
			k = c % 16;
			e = k > 0 && v[k - 1] && (k < 4 || k > 13 || compare_unit_pwm_mode_in[k - 4]);
			r = c > 19 && c < 30 ? 10'h1 << (c - 20) : 10'h0;
			#1 chk(carrier_low_out, e ^ c[4]);
			chk(compare_pin_release_out, r);
		end
	endtask
	task automatic t_wait;
		apb(1'h1, 12'h0, 8'h60);
		apb(1'h1, 12'h4, 8'h80);
		apb(1'h0, 12'h4, 8'h0);
		chk(rd, 32'h80);
		modulation_in <= 1'h1;
		repeat (8) @(posedge sys_clk_in) #1 chk(mod_out, 32'h1);
		apb(1'h0, 12'h8, 8'h0);
		chk(rd, 32'h7);
		apb(1'h1, 12'h0, 8'h20);
		repeat (3) @(posedge sys_clk_in);
		@(posedge sys_clk_in) e = v[15];
		#1 chk(mod_out, e);
		apb(1'h1, 12'h4, 8'h0);
		@(posedge sys_clk_in) #1 chk(mod_out, 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk_in);
		sys_rst_in <= 1'h0;
		t_src;
		t_wait;
		final_report;
	end
	task automatic final_report;
		fail_count += cyc > 2000;
		if (fail_count == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
endmodule // mcls_bench
`default_nettype wire
